// *** dv/snt_remote.sv ***
// remote serial device: captures frames from the block, sends frames to it
`timescale 1ns/1ps
module snt_remote #(
  parameter int BIT_T = 16
) (
  // clock
  input  wire logic        pclk,
  // line from the block
  input  wire logic        serial_tx,
  // line to the block
  output logic             serial_rx,
  // captured frames, newest byte in the low half
  output logic      [15:0] got_hist,
  output logic             got_stop,
  output int               got_cnt
);
  ////////////////////////////////////////////////////////////
  // idle line high until a frame is sent
  initial begin
    serial_rx = 1'b1;
    got_hist = 16'h0000;
    got_stop = 1'b0;
    got_cnt = 0;
  end

  ////////////////////////////////////////////////////////////
  // start confirmed at mid-bit, then one sample per bit centre
  initial begin
    logic [7:0] b;
    forever begin
      do @(posedge pclk); while (serial_tx !== 1'b0);
      repeat (BIT_T / 2) @(posedge pclk);
      if (serial_tx === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_T) @(posedge pclk);
          b[i] = serial_tx;
        end
        repeat (BIT_T) @(posedge pclk);
        got_stop <= serial_tx;
        got_hist <= {got_hist[7:0], b};
        got_cnt <= got_cnt + 1;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // one frame, lsb first; bad_stop makes a break-like low stop bit
  task automatic send(input logic [7:0] d, input logic bad_stop);
    logic [9:0] f;
    f = {~bad_stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rx <= f[i];
      repeat (BIT_T) @(posedge pclk);
    end
    serial_rx <= 1'b1;
    repeat (BIT_T) @(posedge pclk);
  endtask
endmodule

// *** dv/snt_top_tb.sv ***
// self-checking bench for the 8n1 serial transceiver
`timescale 1ns/1ps
`include "snt_defines.svh"
module snt_top_tb;
  // first divider 1, second 8: bit time 16 cycles
  localparam int BT = 16;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        serial_rx, serial_tx, rx_event, tx_event, got_stop;
  logic [31:0] paddr, pwdata, prdata;
  logic [15:0] got_hist;
  int          got_cnt;
  int          failures = 0;
  int          comparisons = 0;
  int          rx_n = 0;
  int          tx_n = 0;

  ////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  snt_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_rx(serial_rx),
    .serial_tx(serial_tx), .rx_event(rx_event), .tx_event(tx_event)
  );

  snt_remote #(.BIT_T(BT)) remote (
    .pclk(pclk), .serial_tx(serial_tx), .serial_rx(serial_rx),
    .got_hist(got_hist), .got_stop(got_stop), .got_cnt(got_cnt)
  );

  ////////////////////////////////////////////////////////////
  // event pulses counted mid-cycle, away from the launching edge
  always @(negedge pclk) begin
    if (rx_event === 1'b1) rx_n <= rx_n + 1;
    if (tx_event === 1'b1) tx_n <= tx_n + 1;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; pready sampled at the rising edge, released just after it
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {14'h0, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, wd, r, e);
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] idx, input logic [31:0] exp, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    check(nm, r, exp);
    check({nm, " err"}, {31'h0, e}, {31'h0, xe});
  endtask

  task automatic wait_frames(input int k);
    for (int n = 0; n < 2000 && got_cnt < k; n++) @(posedge pclk);
  endtask

  task automatic stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // watchdog fires at twenty thousand cycles; whole run is under two thousand
  initial begin
    #(20 * 20000);
    failures++;
    stop_test;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, hole, read-only status
    check("tx idle", {31'h0, serial_tx}, 32'h1);
    rd_chk("status rst", `SNT_IDX_STATUS, 32'h0, 1'b0);
    rd_chk("div rst", `SNT_IDX_DIV, 32'h0, 1'b0);
    rd_chk("hole", 16'hfe04, 32'h0, 1'b1);
    wr(`SNT_IDX_STATUS, 32'h1f);
    rd_chk("status wr", `SNT_IDX_STATUS, 32'h0, 1'b0);
    wr(`SNT_IDX_DIV, 32'h0108);
    rd_chk("div", `SNT_IDX_DIV, 32'h0108, 1'b0);
    // transmit: idle load, held byte through alias, write while full dropped
    wr(`SNT_IDX_DATA, 32'hffffff5a);
    rd_chk("tx run", `SNT_IDX_STATUS, 32'h01, 1'b0);
    wr(`SNT_IDX_DATAH, 32'h0000a5c3);
    rd_chk("tx full", `SNT_IDX_STATUS, 32'h03, 1'b0);
    wr(`SNT_IDX_DATA, 32'h77);
    wait_frames(2);
    repeat (12 * BT) @(posedge pclk);
    check("tx bytes", {16'h0, got_hist}, 32'h5aa5);
    check("tx count", 32'(got_cnt), 32'h2);
    check("tx stop", {31'h0, got_stop}, 32'h1);
    check("tx idle end", {31'h0, serial_tx}, 32'h1);
    rd_chk("tx done", `SNT_IDX_STATUS, 32'h0, 1'b0);
    // receive one byte, read through both ports
    remote.send(8'h3c, 1'b0);
    rd_chk("rx full", `SNT_IDX_STATUS, 32'h04, 1'b0);
    rd_chk("rx high", `SNT_IDX_DATAH, 32'h3c00, 1'b0);
    rd_chk("rx data", `SNT_IDX_DATA, 32'h3c, 1'b0);
    rd_chk("rx clr", `SNT_IDX_STATUS, 32'h0, 1'b0);
    // overrun with a low stop bit, then a clean frame clears both
    remote.send(8'h81, 1'b0);
    remote.send(8'h42, 1'b1);
    rd_chk("err flags", `SNT_IDX_STATUS, 32'h1c, 1'b0);
    rd_chk("rx over", `SNT_IDX_DATA, 32'h42, 1'b0);
    remote.send(8'hf0, 1'b0);
    rd_chk("flags clr", `SNT_IDX_STATUS, 32'h04, 1'b0);
    rd_chk("rx last", `SNT_IDX_DATA, 32'hf0, 1'b0);
    check("rx events", 32'(rx_n), 32'h4);
    check("tx events", 32'(tx_n), 32'h2);
    stop_test;
  end
endmodule

// *** include/snt_defines.svh ***
// constants for the 8n1 serial transceiver: register indexes, reset values, frame sizes
`ifndef SNT_DEFINES_SVH
`define SNT_DEFINES_SVH

// register indexes; byte address is four times the index
`define SNT_IDX_STATUS  16'hfe00
`define SNT_IDX_DATA    16'hfe01
`define SNT_IDX_DATAH   16'hfe02
`define SNT_IDX_DIV     16'hfe03

// reset values
`define SNT_DIV_RST     16'h0000
`define SNT_BYTE_RST    8'h00

// frame layout
`define SNT_TX_TICKS    4'ha
`define SNT_LAST_BIT    3'h7

`endif

// *** include/snt_pkg.sv ***
// types shared by the 8n1 serial transceiver modules
package snt_pkg;

  // divider register layout, first field in the upper byte
  typedef struct packed {
    logic [7:0] baud_prescale_first;
    logic [7:0] baud_prescale_second;
  } snt_div_t;

  // status register layout, bit 4 down to bit 0
  typedef struct packed {
    logic stop_bit_error_flag;
    logic receive_overrun_flag;
    logic receive_byte_waiting;
    logic transmit_holding_occupied;
    logic transmit_shifter_active;
  } snt_status_t;

  // receiver sequence
  typedef enum logic [3:0] {
    SNT_RX_IDLE  = 4'h1,
    SNT_RX_START = 4'h2,
    SNT_RX_DATA  = 4'h4,
    SNT_RX_STOP  = 4'h8
  } snt_rx_state_t;

endpackage

// *** src/snt_bit_timer.sv ***
// two-stage bit period timer with mid-bit and end-of-bit ticks
`timescale 1ns/1ps
module snt_bit_timer
  import snt_pkg::*;
(
  // clock and reset
  input  wire logic     pclk,
  input  wire logic     presetn,
  // control
  input  wire logic     restart,
  input  wire snt_div_t div,
  // ticks
  output logic          mid_tick,
  output logic          end_tick
);

  logic [7:0] pre_r;
  logic [7:0] bit_r;

  // prescaler wraps after first+1 clocks, bit counter after second wraps
  wire pre_wrap = (pre_r == div.baud_prescale_first);
  wire at_end   = (bit_r == 8'(div.baud_prescale_second - 8'h01));
  wire at_mid   = (bit_r == {1'b0, div.baud_prescale_second[7:1]});

  assign mid_tick = pre_wrap & at_mid & ~restart;
  assign end_tick = pre_wrap & at_end & ~restart;

  // restart realigns phase so ticks fall relative to the start edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 8'h00;
      bit_r <= 8'h00;
    end else if (restart) begin
      pre_r <= 8'h00;
      bit_r <= 8'h00;
    end else if (pre_wrap) begin
      pre_r <= 8'h00;
      bit_r <= at_end ? 8'h00 : 8'(bit_r + 8'h01);
    end else begin
      pre_r <= 8'(pre_r + 8'h01);
    end
  end

endmodule

// *** src/snt_top.sv ***
// 8n1 serial transceiver with apb register access
`timescale 1ns/1ps
`include "snt_defines.svh"
module snt_top
  import snt_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line
  input  wire logic        serial_rx,
  output logic             serial_tx,
  // event pulses
  output logic             rx_event,
  output logic             tx_event
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  snt_div_t      div_r;
  snt_rx_state_t rx_state_r;
  logic [7:0]    rx_data_r;
  logic [7:0]    rx_sh_r;
  logic [2:0]    rx_cnt_r;
  logic          rx_full_r;
  logic          orun_r;
  logic          frm_r;
  logic          rxd_prev_r;
  logic [7:0]    hold_r;
  logic          hold_full_r;
  logic          pready_r;
  logic [31:0]   prdata_r;
  logic          pslverr_r;
  logic          rx_event_r;
  logic          tx_event_r;
  logic          tx_busy;
  logic          tx_done;
  logic          tx_tick;
  logic          rx_mid;
  snt_status_t   status;

  // word-aligned address match for one register index
  function automatic logic snt_hit(input logic [31:0] a, input logic [15:0] idx);
    return a == {14'h0, idx, 2'h0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  // one wait state: data is captured first, side effects at the pready edge
  wire acc     = psel & penable;
  wire capture = acc & ~pready_r;
  wire commit  = acc & pready_r;
  wire hit_st  = snt_hit(paddr, `SNT_IDX_STATUS);
  wire hit_dt  = snt_hit(paddr, `SNT_IDX_DATA);
  wire hit_dh  = snt_hit(paddr, `SNT_IDX_DATAH);
  wire hit_dv  = snt_hit(paddr, `SNT_IDX_DIV);
  wire mapped  = hit_st | hit_dt | hit_dh | hit_dv;

  // status view of the block's own state, one driver for the whole word
  assign status = {frm_r,
                   orun_r,
                   rx_full_r,
                   hold_full_r,
                   tx_busy};

  // read mux; unmapped reads give zero with an error
  wire [31:0] rd_status = {27'h0, status};
  wire [31:0] rd_data   = {24'h000000, rx_data_r};
  wire [31:0] rd_datah  = {16'h0000, rx_data_r, 8'h00};
  wire [31:0] rd_div    = {16'h0000, div_r};
  wire [31:0] rd_word   = hit_st ? rd_status :
                          hit_dt ? rd_data   :
                          hit_dh ? rd_datah  :
                          hit_dv ? rd_div    : 32'h00000000;

  // write strobes; status writes are accepted and dropped
  wire wr_data  = commit & pwrite & (hit_dt | hit_dh);
  wire wr_div   = commit & pwrite & hit_dv;
  wire rd_clear = commit & ~pwrite & (hit_dt | hit_dh);
  wire [7:0] wr_byte = hit_dh ? pwdata[15:8] : pwdata[7:0];

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= capture;
      pslverr_r <= capture & ~mapped;
      if (capture && !pwrite) begin
        prdata_r <= rd_word;
      end
    end
  end

  // divider register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= `SNT_DIV_RST;
    end else if (wr_div) begin
      div_r <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit path

  // a write while the holding register is full is not allowed and is dropped
  wire wr_ok     = wr_data & ~hold_full_r;
  wire load_hold = hold_full_r & ~tx_busy;
  wire load_now  = wr_ok & ~tx_busy;
  wire to_hold   = wr_ok & tx_busy;
  wire tx_load   = load_hold | load_now;
  wire [7:0] tx_byte = hold_full_r ? hold_r : wr_byte;

  // holding register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r      <= `SNT_BYTE_RST;
      hold_full_r <= 1'b0;
    end else if (to_hold) begin
      hold_r      <= wr_byte;
      hold_full_r <= 1'b1;
    end else if (load_hold) begin
      hold_full_r <= 1'b0;
    end
  end

  // transmit event on every byte entering the shifter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_event_r <= 1'b0;
    end else begin
      tx_event_r <= tx_load;
    end
  end

  // transmit bit timer restarts with each character
  snt_bit_timer u_tx_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .restart  (tx_load),
    .div      (div_r),
    .mid_tick (),
    .end_tick (tx_tick)
  );

  // transmit shifter drives the line straight from its flop
  snt_tx_shifter u_tx_shift (
    .pclk     (pclk),
    .presetn  (presetn),
    .load     (tx_load),
    .data     (tx_byte),
    .bit_tick (tx_tick),
    .busy     (tx_busy),
    .done     (tx_done),
    .txd      (serial_tx)
  );

  ////////////////////////////////////////////////////////////////////////////
  // receive path

  // start is a falling edge seen while idle; a break that stays low never rearms
  wire rx_start  = (rx_state_r == SNT_RX_IDLE) & rxd_prev_r & ~serial_rx;
  wire rx_commit = (rx_state_r == SNT_RX_STOP) & rx_mid;

  // receive bit timer, phase aligned to the start edge
  snt_bit_timer u_rx_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .restart  (rx_start),
    .div      (div_r),
    .mid_tick (rx_mid),
    .end_tick ()
  );

  // receiver sequence sampled at mid-bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_r <= SNT_RX_IDLE;
      rx_sh_r    <= `SNT_BYTE_RST;
      rx_cnt_r   <= 3'h0;
      rxd_prev_r <= 1'b1;
    end else begin
      rxd_prev_r <= serial_rx;
      case (rx_state_r)
        SNT_RX_IDLE: begin
          if (rx_start) begin
            rx_state_r <= SNT_RX_START;
          end
        end
        SNT_RX_START: begin
          if (rx_mid) begin
            rx_state_r <= serial_rx ? SNT_RX_IDLE : SNT_RX_DATA;
            rx_cnt_r   <= 3'h0;
          end
        end
        SNT_RX_DATA: begin
          if (rx_mid) begin
            rx_sh_r  <= {serial_rx, rx_sh_r[7:1]};
            rx_cnt_r <= 3'(rx_cnt_r + 3'h1);
            if (rx_cnt_r == `SNT_LAST_BIT) begin
              rx_state_r <= SNT_RX_STOP;
            end
          end
        end
        SNT_RX_STOP: begin
          if (rx_mid) begin
            rx_state_r <= SNT_RX_IDLE;
          end
        end
        default: begin
          rx_state_r <= SNT_RX_IDLE;
        end
      endcase
    end
  end

  // receive data register and its flags; a new byte wins over a read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_r  <= `SNT_BYTE_RST;
      rx_full_r  <= 1'b0;
      orun_r     <= 1'b0;
      frm_r      <= 1'b0;
      rx_event_r <= 1'b0;
    end else begin
      rx_event_r <= rx_commit;
      if (rx_commit) begin
        rx_data_r <= rx_sh_r;
        rx_full_r <= 1'b1;
        orun_r    <= rx_full_r;
        frm_r     <= ~serial_rx;
      end else if (rd_clear) begin
        rx_full_r <= 1'b0;
      end
    end
  end

  // outputs
  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign rx_event = rx_event_r;
  assign tx_event = tx_event_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_idle_high;
    @(posedge pclk) disable iff (!presetn) !tx_busy |-> serial_tx;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("tx line low while idle");

  property p_start_low;
    @(posedge pclk) disable iff (!presetn) tx_load |=> !serial_tx && tx_busy;
  endproperty
  a_start_low: assert property (p_start_low) else $error("no start bit after load");

  property p_running;
    @(posedge pclk) disable iff (!presetn) tx_load |=> status.transmit_shifter_active;
  endproperty
  a_running: assert property (p_running) else $error("running flag missing");

  property p_hold_set;
    @(posedge pclk) disable iff (!presetn) to_hold |=> hold_full_r && hold_r == $past(wr_byte);
  endproperty
  a_hold_set: assert property (p_hold_set) else $error("holding register not filled");

  property p_hold_drain;
    @(posedge pclk) disable iff (!presetn)
      tx_done && hold_full_r |=> !hold_full_r && tx_event && tx_busy && !serial_tx;
  endproperty
  a_hold_drain: assert property (p_hold_drain) else $error("holding byte not sent");

  property p_tx_event;
    @(posedge pclk) disable iff (!presetn) load_now |=> tx_event && tx_busy;
  endproperty
  a_tx_event: assert property (p_tx_event) else $error("no transmit event");

  property p_overrun;
    @(posedge pclk) disable iff (!presetn) rx_commit |=> orun_r == $past(rx_full_r);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun flag wrong");

  property p_framing;
    @(posedge pclk) disable iff (!presetn) rx_commit |=> frm_r == !$past(serial_rx);
  endproperty
  a_framing: assert property (p_framing) else $error("framing flag wrong");

  property p_rx_event;
    @(posedge pclk) disable iff (!presetn) rx_commit |=> rx_event && rx_full_r;
  endproperty
  a_rx_event: assert property (p_rx_event) else $error("no receive event");

  property p_rd_clear;
    @(posedge pclk) disable iff (!presetn) rd_clear && !rx_commit |=> !rx_full_r;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read did not clear full");

  property p_rd_low;
    @(posedge pclk) disable iff (!presetn) capture && !pwrite && hit_dt |=> prdata[31:8] == 24'h000000;
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("data read upper bits set");

  property p_rd_high;
    @(posedge pclk) disable iff (!presetn)
      capture && !pwrite && hit_dh |=> prdata[7:0] == 8'h00 && prdata[15:8] == $past(rx_data_r);
  endproperty
  a_rd_high: assert property (p_rd_high) else $error("alias read misplaced");

  // a write into a full holding register must leave the held byte alone
  property p_full_drop;
    @(posedge pclk) disable iff (!presetn)
      wr_data && hold_full_r && tx_busy |=> hold_full_r && hold_r == $past(hold_r);
  endproperty
  a_full_drop: assert property (p_full_drop) else $error("write while full not dropped");

  property p_stop_high;
    @(posedge pclk) disable iff (!presetn) tx_done |-> serial_tx && !tx_busy;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("line low after stop bit");

  property p_div_hold;
    @(posedge pclk) disable iff (!presetn) !wr_div |=> div_r == $past(div_r);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider changed without write");

  property p_rx_load;
    @(posedge pclk) disable iff (!presetn) rx_commit |=> rx_data_r == $past(rx_sh_r);
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("received byte not stored");

  property p_rx_rearm;
    @(posedge pclk) disable iff (!presetn) rx_commit |=> rx_state_r == SNT_RX_IDLE;
  endproperty
  a_rx_rearm: assert property (p_rx_rearm) else $error("receiver not idle after stop");

endmodule

// *** src/snt_tx_shifter.sv ***
// transmit shift register for one 8n1 character
`timescale 1ns/1ps
module snt_tx_shifter
  import snt_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // byte in
  input  wire logic       load,
  input  wire logic [7:0] data,
  input  wire logic       bit_tick,
  // state and line
  output logic            busy,
  output logic            done,
  output logic            txd
);

  logic [8:0] sh_r;
  logic [3:0] cnt_r;

  // start bit goes out on load, then data lsb first, then the stop bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r  <= 9'h1ff;
      cnt_r <= 4'h0;
      busy  <= 1'b0;
      done  <= 1'b0;
      txd   <= 1'b1;
    end else begin
      done <= 1'b0;
      if (load) begin
        sh_r  <= {1'b1, data};
        cnt_r <= `SNT_TX_TICKS;
        busy  <= 1'b1;
        txd   <= 1'b0;
      end else if (busy && bit_tick) begin
        if (cnt_r == 4'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
          txd  <= 1'b1;
        end else begin
          txd   <= sh_r[0];
          sh_r  <= {1'b1, sh_r[8:1]};
          cnt_r <= 4'(cnt_r - 4'h1);
        end
      end
    end
  end

endmodule
